// File: include/pmbac_pkg.sv
// package: constants, types and rule summary for the prefetch miss buffer block
//
// Operation
// - aligned only when address multiple of size; code checks ten-byte access on 8-byte boundary
// - misaligned access costs one extra cycle
// - size-mismatched store reuse stalls the load
// - prefetch accepted from any code context
// - write-intent fill installs line as Modified
// - modified install skips ownership upgrade cost
// - six outstanding prefetches, one slot each
// - all slots full: drop new prefetch
// - issue prefetches to memory in order
// - fetch whole aligned 64-byte line
// - hold prefetch behind matching pending store; code accepts it instead on a cache hit or a line already in a slot
package pmbac_pkg;
    // -----------------------------------------------------------------
    // sizes and timing
    // -----------------------------------------------------------------
    localparam int ADDR_W       = 32;
    localparam int SLOTS        = 6;
    localparam int LINE_BYTES   = 64;
    localparam int LINE_OFS_W   = 6;
    localparam int LINE_W       = ADDR_W - LINE_OFS_W;
    localparam int SLOT_IDX_W   = 3;
    localparam int MISALIGN_PEN = 1;
    localparam logic [1:0] PEN_CNT = 2'h1;

    // access size codes
    localparam logic [2:0] SZ_BYTE  = 3'h0;
    localparam logic [2:0] SZ_WORD  = 3'h1;
    localparam logic [2:0] SZ_DWORD = 3'h2;
    localparam logic [2:0] SZ_QWORD = 3'h3;
    localparam logic [2:0] SZ_TEN   = 3'h4;  // ten_byte_access

    // coherence state of an installed line
    typedef enum logic [1:0] {
        PMBAC_ST_I = 2'b00,
        PMBAC_ST_S = 2'b01,
        PMBAC_ST_E = 2'b10,
        PMBAC_ST_M = 2'b11
    } pmbac_coh_e;

    // prefetch request from the core
    typedef struct packed {
        logic              valid;
        logic              write_intent_fill;
        logic [ADDR_W-1:0] addr;
    } pmbac_pf_req_s;

    // load/store access presented for alignment and forwarding checks
    typedef struct packed {
        logic              valid;
        logic              is_load;
        logic [2:0]        size;
        logic [ADDR_W-1:0] addr;
        logic [2:0]        st_size;   // size of matching buffered store
        logic              st_hit;    // buffered store overlaps this load
        logic              st_same;   // buffered store has same start address
    } pmbac_ls_req_s;

    // line request to memory
    typedef struct packed {
        logic              valid;
        logic [SLOT_IDX_W-1:0] tag;
        logic [LINE_W-1:0] line;
        logic              write_intent_fill;
    } pmbac_mem_req_s;

    // line install toward the cache
    typedef struct packed {
        logic              valid;
        logic [LINE_W-1:0] line;
        pmbac_coh_e        state;
    } pmbac_install_s;
endpackage

// File: core/pmbac_align_chk.sv
// module: alignment check and store-forward stall decision
`timescale 1ns/1ps
module pmbac_align_chk
    import pmbac_pkg::*;
(
    // access under check
    input  wire pmbac_pkg::pmbac_ls_req_s req,
    // results
    output logic                         misaligned,
    output logic                         fwd_stall
);
    // -----------------------------------------------------------------
    // natural alignment; ten-byte access checked on 8-byte boundary
    // -----------------------------------------------------------------
    always_comb begin
        case (req.size)
            SZ_WORD:  misaligned = req.addr[0];
            SZ_DWORD: misaligned = |req.addr[1:0];
            SZ_QWORD: misaligned = |req.addr[2:0];
            SZ_TEN:   misaligned = |req.addr[2:0];
            default:  misaligned = 1'b0;
        endcase
    end

    // -----------------------------------------------------------------
    // forwarding allowed only for same start, same size, both aligned
    // -----------------------------------------------------------------
    always_comb begin
        fwd_stall = 1'b0;
        if (req.valid && req.is_load && req.st_hit) begin
            // store size differs either way, start offset differs, or load misaligned
            if (req.st_size != req.size || !req.st_same || misaligned) begin
                fwd_stall = 1'b1;
            end
        end
    end
endmodule

// File: core/pmbac_top.sv
// module: prefetch miss buffer with alignment penalty and forward stall
`timescale 1ns/1ps
module pmbac_top
    import pmbac_pkg::*;
#(
    parameter int NSLOT = SLOTS
) (
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     reset_n,
    // load/store pipeline
    input  wire pmbac_pkg::pmbac_ls_req_s ls_req,
    output logic                          ls_stall,
    output logic                          ls_misaligned,
    output logic                          ls_fwd_stall,
    // prefetch request from core
    input  wire pmbac_pkg::pmbac_pf_req_s pf_req,
    input  wire logic                     pf_cache_hit,
    input  wire logic                     pf_store_pending,
    output logic                          pf_accept,
    output logic                          pf_dropped,
    output logic                          pf_full,
    // memory request and fill
    output pmbac_pkg::pmbac_mem_req_s     mem_req,
    input  wire logic                     mem_req_ready,
    input  wire logic                     mem_fill_valid,
    input  wire logic [SLOT_IDX_W-1:0]    mem_fill_tag,
    // line install toward cache
    output pmbac_pkg::pmbac_install_s     install
);
    // -----------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------
    logic                  chk_mis;               // combinational misalign
    logic                  chk_fwd;               // combinational forward stall
    logic [1:0]            pen_q, pen_d;          // penalty cycle counter
    logic [NSLOT-1:0]      vld_q, vld_d;          // slot busy
    logic [NSLOT-1:0]      sent_q, sent_d;        // slot sent to memory
    logic [NSLOT-1:0]      wi_q, wi_d;            // slot write intent
    logic [LINE_W-1:0]     line_q [NSLOT];        // slot line address
    logic [LINE_W-1:0]     line_d [NSLOT];
    logic [NSLOT-1:0]      match;                 // request line already held
    logic [SLOT_IDX_W-1:0] free_idx;              // first free slot
    logic                  any_free;
    logic [SLOT_IDX_W-1:0] head_q, head_d;        // oldest unsent slot
    logic [SLOT_IDX_W-1:0] tail_q, tail_d;        // next allocation order
    logic [SLOT_IDX_W-1:0] ord_q [NSLOT];         // allocation queue
    logic [SLOT_IDX_W-1:0] ord_d [NSLOT];
    logic [SLOT_IDX_W:0]   qcnt_q, qcnt_d;        // unsent entries
    logic [LINE_W-1:0]     req_line;
    logic                  stall_d, mis_d, fwd_d, acc_d, drop_d, full_d;
    pmbac_mem_req_s        mreq_q, mreq_d;
    pmbac_install_s        inst_q, inst_d;
    logic                  ls_stall_q, mis_q, fwd_q, acc_q, drop_q, full_q;

    // -----------------------------------------------------------------
    // alignment and forwarding checker
    // -----------------------------------------------------------------
    pmbac_align_chk u_chk (
        .req        (ls_req),
        .misaligned (chk_mis),
        .fwd_stall  (chk_fwd)
    );

    // -----------------------------------------------------------------
    // slot lookup
    // -----------------------------------------------------------------
    assign req_line = pf_req.addr[ADDR_W-1:LINE_OFS_W];

    // per-slot line comparison
    for (genvar g = 0; g < NSLOT; g++) begin : g_match
        assign match[g] = vld_q[g] && (line_q[g] == req_line);
    end

    // lowest free slot
    always_comb begin
        any_free = 1'b0;
        free_idx = '0;
        for (int i = NSLOT - 1; i >= 0; i--) begin
            if (!vld_q[i]) begin
                any_free = 1'b1;
                free_idx = SLOT_IDX_W'(i);
            end
        end
    end

    // -----------------------------------------------------------------
    // load/store next state: one extra cycle when misaligned
    // -----------------------------------------------------------------
    always_comb begin
        pen_d   = '0;
        mis_d   = 1'b0;
        fwd_d   = 1'b0;
        stall_d = 1'b0;
        if (pen_q != '0) begin
            // penalty cycle in progress
            pen_d   = pen_q - 2'h1;
            stall_d = (pen_q != 2'h1);
        end else if (ls_req.valid) begin
            mis_d = chk_mis;
            fwd_d = chk_fwd;
            if (chk_mis) begin
                pen_d   = PEN_CNT;
                stall_d = 1'b1;
            end
            if (chk_fwd) begin
                stall_d = 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // miss buffer next state
    // -----------------------------------------------------------------
    always_comb begin
        vld_d  = vld_q;
        sent_d = sent_q;
        wi_d   = wi_q;
        line_d = line_q;
        ord_d  = ord_q;
        head_d = head_q;
        tail_d = tail_q;
        qcnt_d = qcnt_q;
        acc_d  = 1'b0;
        drop_d = 1'b0;
        mreq_d = mreq_q;
        inst_d = '0;
        // memory takes the oldest request, then the next one is offered
        if (mreq_q.valid && mem_req_ready) begin
            mreq_d.valid = 1'b0;
        end
        // fill returns: install and release slot
        if (mem_fill_valid && vld_q[mem_fill_tag]) begin
            vld_d[mem_fill_tag]  = 1'b0;
            sent_d[mem_fill_tag] = 1'b0;
            inst_d.valid = 1'b1;
            inst_d.line  = line_q[mem_fill_tag];
            // write intent lands straight in Modified, no upgrade later
            inst_d.state = wi_q[mem_fill_tag] ? PMBAC_ST_M : PMBAC_ST_E;
        end
        // new prefetch, whatever code context issued it
        if (pf_req.valid) begin
            if (pf_cache_hit || (|match)) begin
                acc_d = 1'b1;
            end else if (pf_store_pending) begin
                drop_d = 1'b0;
            end else if (!any_free) begin
                drop_d = 1'b1;
            end else begin
                acc_d            = 1'b1;
                vld_d[free_idx]  = 1'b1;
                wi_d[free_idx]   = pf_req.write_intent_fill;
                line_d[free_idx] = req_line;
                ord_d[tail_q]    = free_idx;
                tail_d = (tail_q == SLOT_IDX_W'(NSLOT - 1)) ? '0 : tail_q + 3'h1;
                qcnt_d = qcnt_d + 4'h1;
            end
        end
        // offer next unsent slot in arrival order
        if (!mreq_d.valid && qcnt_q != '0) begin
            mreq_d.valid             = 1'b1;
            mreq_d.tag               = ord_q[head_q];
            mreq_d.line              = line_q[ord_q[head_q]];
            mreq_d.write_intent_fill = wi_q[ord_q[head_q]];
            sent_d[ord_q[head_q]]    = 1'b1;
            head_d = (head_q == SLOT_IDX_W'(NSLOT - 1)) ? '0 : head_q + 3'h1;
            qcnt_d = qcnt_d - 4'h1;
        end
        full_d = &vld_d;
    end

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pen_q      <= '0;
            vld_q      <= '0;
            sent_q     <= '0;
            wi_q       <= '0;
            head_q     <= '0;
            tail_q     <= '0;
            qcnt_q     <= '0;
            mreq_q     <= '0;
            inst_q     <= '0;
            ls_stall_q <= 1'b0;
            mis_q      <= 1'b0;
            fwd_q      <= 1'b0;
            acc_q      <= 1'b0;
            drop_q     <= 1'b0;
            full_q     <= 1'b0;
            for (int i = 0; i < NSLOT; i++) begin
                line_q[i] <= '0;
                ord_q[i]  <= '0;
            end
        end else begin
            pen_q      <= pen_d;
            vld_q      <= vld_d;
            sent_q     <= sent_d;
            wi_q       <= wi_d;
            line_q     <= line_d;
            ord_q      <= ord_d;
            head_q     <= head_d;
            tail_q     <= tail_d;
            qcnt_q     <= qcnt_d;
            mreq_q     <= mreq_d;
            inst_q     <= inst_d;
            ls_stall_q <= stall_d;
            mis_q      <= mis_d;
            fwd_q      <= fwd_d;
            acc_q      <= acc_d;
            drop_q     <= drop_d;
            full_q     <= full_d;
        end
    end

    // -----------------------------------------------------------------
    // outputs straight from flip-flops
    // -----------------------------------------------------------------
    assign ls_stall      = ls_stall_q;
    assign ls_misaligned = mis_q;
    assign ls_fwd_stall  = fwd_q;
    assign pf_accept     = acc_q;
    assign pf_dropped    = drop_q;
    assign pf_full       = full_q;
    assign mem_req       = mreq_q;
    assign install       = inst_q;
endmodule

// File: verification/pmbac_top_assertions.sv
// checker: port-level properties of the prefetch miss buffer block
`timescale 1ns/1ps
module pmbac_top_checker
    import pmbac_pkg::*;
#(
    parameter int NSLOT = SLOTS
) (
    // clock and reset
    input wire logic                     clk_sys,
    input wire logic                     reset_n,
    // load/store pipeline
    input wire pmbac_pkg::pmbac_ls_req_s ls_req,
    input wire logic                     ls_stall,
    input wire logic                     ls_misaligned,
    input wire logic                     ls_fwd_stall,
    // prefetch side
    input wire pmbac_pkg::pmbac_pf_req_s pf_req,
    input wire logic                     pf_cache_hit,
    input wire logic                     pf_store_pending,
    input wire logic                     pf_accept,
    input wire logic                     pf_dropped,
    input wire logic                     pf_full,
    // memory and install
    input wire pmbac_pkg::pmbac_mem_req_s mem_req,
    input wire logic                     mem_req_ready,
    input wire logic                     mem_fill_valid,
    input wire logic [SLOT_IDX_W-1:0]    mem_fill_tag,
    input wire pmbac_pkg::pmbac_install_s install
);
    // -----------------------------------------------------------------
    // helper logic
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic mis_c;   // access breaks natural alignment
    logic take_c;  // access is taken, no penalty cycle running
    // natural alignment per access size; ten-byte access checked on 8-byte boundary
    always_comb begin
        case (ls_req.size)
            SZ_WORD: mis_c = ls_req.addr[0];
            SZ_DWORD: mis_c = |ls_req.addr[1:0];
            SZ_QWORD, SZ_TEN: mis_c = |ls_req.addr[2:0];
            default: mis_c = 1'b0;
        endcase
    end
    assign take_c = ls_req.valid && !ls_misaligned;
    // -----------------------------------------------------------------
    // properties
    // -----------------------------------------------------------------
    a_mis_flag: assert property (take_c && mis_c |=> ls_misaligned && ls_stall)
        else $error("misaligned access gave no penalty");
    a_align_clean: assert property (take_c && !mis_c |=> !ls_misaligned)
        else $error("aligned access flagged misaligned");
    a_pen_once: assert property (ls_misaligned |=> !ls_stall && !ls_misaligned)
        else $error("penalty lasted more than one cycle");
    a_fwd_size: assert property (take_c && ls_req.is_load && ls_req.st_hit
        && ls_req.st_size != ls_req.size |=> ls_fwd_stall && ls_stall)
        else $error("size mismatched load was forwarded");
    a_fwd_ok: assert property (take_c && ls_req.is_load && ls_req.st_hit && ls_req.st_same
        && ls_req.st_size == ls_req.size && !mis_c |=> !ls_fwd_stall)
        else $error("matching load was stalled");
    a_pf_drop: assert property (pf_req.valid && pf_full && !pf_cache_hit
        && !pf_store_pending && !mem_fill_valid |=> pf_dropped && !pf_accept)
        else $error("prefetch not dropped while full");
    a_pf_held: assert property (pf_req.valid && pf_store_pending |=> !pf_accept && !pf_dropped)
        else $error("store pending prefetch was answered");
    a_hit_acc: assert property (pf_req.valid && pf_cache_hit && !pf_store_pending |=> pf_accept)
        else $error("cache hit prefetch not accepted");
    a_req_keep: assert property (mem_req.valid && !mem_req_ready |=> $stable(mem_req))
        else $error("memory request changed before taken");
    a_fill_inst: assert property (install.valid |-> $past(mem_fill_valid))
        else $error("install without a fill");
    // main scenarios
    c_mis: cover property (take_c && mis_c);
    c_drop: cover property (pf_dropped);
    c_mod: cover property (install.valid && install.state == PMBAC_ST_M);
endmodule

bind pmbac_top pmbac_top_checker #(.NSLOT(NSLOT)) u_assert (.clk_sys, .reset_n, .ls_req,
    .ls_stall, .ls_misaligned, .ls_fwd_stall, .pf_req, .pf_cache_hit, .pf_store_pending,
    .pf_accept, .pf_dropped, .pf_full, .mem_req, .mem_req_ready, .mem_fill_valid,
    .mem_fill_tag, .install);

// File: verification/pmbac_mem_model.sv
// memory side model: takes line requests one at a time and returns fills
`timescale 1ns/1ps
module pmbac_mem_model
    import pmbac_pkg::*;
(
    // clock, reset and stall control
    input  wire logic                      clk_sys,
    input  wire logic                      reset_n,
    input  wire logic                      hold,
    // request and fill
    input  wire pmbac_pkg::pmbac_mem_req_s mem_req,
    output logic                           mem_req_ready,
    output logic                           mem_fill_valid,
    output logic [SLOT_IDX_W-1:0]          mem_fill_tag
);
    logic [SLOT_IDX_W-1:0] tag_q;  // slot of the line in flight
    logic [3:0]            cnt_q;  // cycles until fill, 0 when idle
    // ready only when idle and not stalled
    assign mem_req_ready = reset_n && !hold && cnt_q == 4'h0;
    // tag is scrambled outside the fill pulse
    assign mem_fill_tag = mem_fill_valid ? tag_q : ~tag_q;
    // latency counter and fill pulse
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 4'h0;
            tag_q <= '0;
            mem_fill_valid <= 1'b0;
        end else begin
            mem_fill_valid <= 1'b0;
            if (mem_req.valid && mem_req_ready) begin
                tag_q <= mem_req.tag;
                cnt_q <= 4'h5;
            end else if (cnt_q == 4'h1) begin
                mem_fill_valid <= 1'b1;
                cnt_q <= 4'h0;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule

// File: verification/test_prefetch_miss_buffer_and_align_check.sv
// testbench: alignment, forward stall and prefetch slot behaviour
`timescale 1ns/1ps
module test_prefetch_miss_buffer_and_align_check;
    import pmbac_pkg::*;
    typedef struct packed {
        logic [2:0] size;
        logic [7:0] ofs;
        logic       load;
        logic       st_hit;
        logic       st_same;
        logic [2:0] st_size;
        logic       mis;
        logic       fwd;
    } pmbac_row_s;
    logic clk_sys, reset_n, ls_stall, ls_misaligned, ls_fwd_stall, hold;
    logic pf_cache_hit, pf_store_pending, pf_accept, pf_dropped, pf_full;
    logic mem_req_ready, mem_fill_valid;
    logic [SLOT_IDX_W-1:0] mem_fill_tag;
    pmbac_ls_req_s  ls_req;
    pmbac_pf_req_s  pf_req;
    pmbac_mem_req_s mem_req;
    pmbac_install_s install;
    int n_fail, check_count, cyc;
    logic [26:0] got_line [$];  // write intent and line taken by memory, in order
    logic [1:0]  got_st [$];    // installed states, in order
    logic [25:0] got_inst [$];  // installed lines, in order
    // ordinary access cases: size, offset, store match, expected flags
    pmbac_row_s rows [13] = '{
        '{SZ_BYTE, 8'h03, 1'b0, 1'b0, 1'b0, SZ_BYTE, 1'b0, 1'b0},
        '{SZ_WORD, 8'h02, 1'b0, 1'b0, 1'b0, SZ_BYTE, 1'b0, 1'b0},
        '{SZ_WORD, 8'h03, 1'b0, 1'b0, 1'b0, SZ_BYTE, 1'b1, 1'b0},
        '{SZ_DWORD, 8'h04, 1'b0, 1'b0, 1'b0, SZ_BYTE, 1'b0, 1'b0},
        '{SZ_DWORD, 8'h06, 1'b0, 1'b0, 1'b0, SZ_BYTE, 1'b1, 1'b0},
        '{SZ_QWORD, 8'h08, 1'b0, 1'b0, 1'b0, SZ_BYTE, 1'b0, 1'b0},
        '{SZ_QWORD, 8'h0c, 1'b0, 1'b0, 1'b0, SZ_BYTE, 1'b1, 1'b0},
        '{SZ_TEN, 8'h18, 1'b0, 1'b0, 1'b0, SZ_BYTE, 1'b0, 1'b0},
        '{SZ_TEN, 8'h1c, 1'b0, 1'b0, 1'b0, SZ_BYTE, 1'b1, 1'b0},
        '{SZ_DWORD, 8'h20, 1'b1, 1'b1, 1'b1, SZ_WORD, 1'b0, 1'b1},
        '{SZ_DWORD, 8'h20, 1'b1, 1'b1, 1'b1, SZ_QWORD, 1'b0, 1'b1},
        '{SZ_WORD, 8'h22, 1'b1, 1'b1, 1'b0, SZ_DWORD, 1'b0, 1'b1},
        '{SZ_DWORD, 8'h20, 1'b1, 1'b1, 1'b1, SZ_DWORD, 1'b0, 1'b0}
    };
    // ---------------------------------------------------------------
    // design, memory model, clock
    // ---------------------------------------------------------------
    pmbac_top DUT (.clk_sys, .reset_n, .ls_req, .ls_stall, .ls_misaligned, .ls_fwd_stall,
        .pf_req, .pf_cache_hit, .pf_store_pending, .pf_accept, .pf_dropped, .pf_full,
        .mem_req, .mem_req_ready, .mem_fill_valid, .mem_fill_tag, .install);
    pmbac_mem_model u_mem (.clk_sys, .reset_n, .hold, .mem_req, .mem_req_ready,
        .mem_fill_valid, .mem_fill_tag);
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // record memory takes and installs; hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (mem_req.valid && mem_req_ready) got_line.push_back({mem_req.write_intent_fill,
            mem_req.line});
        if (install.valid) begin
            got_st.push_back(install.state);
            got_inst.push_back(install.line);
        end
        if (cyc == 3000) begin
            n_fail++;
            results();
        end
    end
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one prefetch cycle, answer checked one cycle later
    task automatic pf(input logic [25:0] line, input logic wi, input logic hit,
                      input logic pend, input logic [1:0] exp);
        pf_req = '{1'b1, wi, {line, 6'h2a}};
        pf_cache_hit = hit;
        pf_store_pending = pend;
        @(negedge clk_sys);
        chk({pf_accept, pf_dropped}, exp);
    endtask
    task automatic wait_inst(input int n);
        for (int k = 0; k < 300 && got_st.size() < n; k++) @(negedge clk_sys);
    endtask
    task automatic results();
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {reset_n, hold, pf_cache_hit, pf_store_pending} = 4'h0;
        ls_req = '0;
        pf_req = '0;
        repeat (20) @(negedge clk_sys);
        reset_n = 1'b1;
        chk({pf_full, pf_accept, mem_req.valid, install.valid, ls_stall}, 0);
        foreach (rows[i]) begin
            ls_req = '{1'b1, rows[i].load, rows[i].size, 32'h1000 | rows[i].ofs,
                       rows[i].st_size, rows[i].st_hit, rows[i].st_same};
            @(negedge clk_sys);
            ls_req.valid = 1'b0;
            chk(ls_misaligned, rows[i].mis);
            chk(ls_fwd_stall, rows[i].fwd);
            chk(ls_stall, rows[i].mis | rows[i].fwd);
            @(negedge clk_sys);
        end
        // misaligned access held for two cycles: second lands in penalty
        ls_req = '{1'b1, 1'b0, SZ_DWORD, 32'h2002, SZ_BYTE, 1'b0, 1'b0};
        @(negedge clk_sys);
        chk(ls_misaligned, 1);
        @(negedge clk_sys);
        ls_req.valid = 1'b0;
        chk({ls_misaligned, ls_stall}, 0);
        // memory stalled: six back-to-back prefetches, then drop, hit, held
        hold = 1'b1;
        for (int i = 0; i < 6; i++) pf(26'h100 + i, i[0], 1'b0, 1'b0, 2'b10);
        chk(pf_full, 1);
        pf(26'h200, 1'b0, 1'b0, 1'b0, 2'b01);
        pf(26'h201, 1'b0, 1'b1, 1'b0, 2'b10);
        pf(26'h202, 1'b1, 1'b0, 1'b1, 2'b00);
        pf_req.valid = 1'b0;
        {pf_cache_hit, pf_store_pending, hold} = 3'h0;
        wait_inst(6);
        chk(got_line.size(), 6);
        for (int i = 0; i < 6; i++) begin
            chk(got_line[i], {i[0], 26'h100 + 26'(i)});
            chk(got_inst[i], 26'h100 + i);
            chk(got_st[i], i[0] ? PMBAC_ST_M : PMBAC_ST_E);
        end
        chk(pf_full, 0);
        // same line twice after release: one slot, one memory request
        hold = 1'b1;
        pf(26'h300, 1'b1, 1'b0, 1'b0, 2'b10);
        pf(26'h300, 1'b1, 1'b0, 1'b0, 2'b10);
        pf_req.valid = 1'b0;
        hold = 1'b0;
        wait_inst(7);
        repeat (20) @(negedge clk_sys);
        chk(got_line.size(), 7);
        chk(got_st.size(), 7);
        chk(got_line[6], {1'b1, 26'h300});
        chk(got_st[6], PMBAC_ST_M);
        results();
    end
endmodule
